/* File: tscs_conv_status.sv */
`timescale 1ns/100ps
module tscs_conv_status
#(
	parameter int CONV_CYC = tscs_pkg::CONV_CYCLES,
	parameter int FAST_CYC = tscs_pkg::FAST_CYCLES
)
(
	// Clock and reset
	input wire logic sysClk,
	input wire logic rst,
	// Strobes from the bus engine, same clock
	input wire logic cfgWrite,
	input wire logic rateWrite,
	input wire logic [7:0] writeData,
	input wire logic statusRead,
	input wire logic oneShot,
	input wire logic araRead,
	input wire logic stopSeen,
	input wire logic busIdle,
	input wire logic addrValid,
	input wire logic [6:0] addrIn,
	// Pins, asynchronous
	input wire logic smbClk,
	input wire logic standbyPinN,
	input wire logic diodeOpen,
	input wire logic [1:0] strapA,
	input wire logic [1:0] strapB,
	// Comparator results, valid at end of conversion
	input wire logic localOver,
	input wire logic localUnder,
	input wire logic remoteOver,
	input wire logic remoteUnder,
	// Converter control
	output logic convStart,
	output logic resultLoad,
	// Register read data
	output logic [7:0] cfgByte,
	output logic [7:0] rateByte,
	output logic [7:0] statusByte,
	output logic [7:0] araByte,
	// Address and alert
	output logic [6:0] slaveAddr,
	output logic addrHit,
	output logic alertO,
	output logic alertOe
);
	import tscs_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [6:0] pinMeta;
	logic [6:0] pinSync;
	logic sclPrev;
	logic sclSync;
	logic stbyPinSync;
	logic openSync;
	logic [1:0] strapASync;
	logic [1:0] strapBSync;

	always_ff @(posedge sysClk or posedge rst)
	begin
		if (rst)
		begin
			// Reset to the idle pin levels, bus clock high and standby
			// released, so that no false edge or standby follows reset.
			pinMeta <= 7'h60;
			pinSync <= 7'h60;
			sclPrev <= 1'b1;
		end
		else
		begin
			pinMeta <= {smbClk, standbyPinN, diodeOpen, strapA, strapB};
			pinSync <= pinMeta;
			sclPrev <= pinSync[6];
		end
	end

	always_comb
	begin
		sclSync = pinSync[6];
		stbyPinSync = pinSync[5];
		openSync = pinSync[4];
		strapASync = pinSync[3:2];
		strapBSync = pinSync[1:0];
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	tscs_state_t state;
	tscs_state_t next_state;
	logic [31:0] convCnt;
	logic [31:0] next_convCnt;
	logic [31:0] rateTimer;
	logic [31:0] next_rateTimer;
	logic oneShotRun;
	logic next_oneShotRun;
	logic [1:0] cfgBits;
	logic [1:0] next_cfgBits;
	logic [RATE_W-1:0] rateCode;
	logic [RATE_W-1:0] next_rateCode;
	logic [4:0] flags;
	logic [4:0] next_flags;
	logic [3:0] thrPend;
	logic [3:0] next_thrPend;
	logic stopArm;
	logic next_stopArm;
	logic alertLatch;
	logic next_alertLatch;
	logic [1:0] strapCnt;
	logic [1:0] next_strapCnt;
	logic strapDone;
	logic next_strapDone;
	logic [6:0] next_slaveAddr;
	logic next_convStart;
	logic next_resultLoad;
	logic [7:0] next_statusByte;
	logic next_addrHit;
	logic next_alertOe;
	logic standby;
	logic startConv;
	logic convEnd;
	logic refresh;
	logic busyNext;
	logic [31:0] newPeriod;

	function automatic logic [31:0] periodOf(input logic [RATE_W-1:0] c);
		periodOf = 32'(FAST_CYC) << (RATE_SLOWEST - c);
	endfunction

	function automatic logic [6:0] addrOf(input logic [1:0] a,
		input logic [1:0] b);
		logic [3:0] ia;
		logic [3:0] ib;
		ia = (a == STRAP_VCC) ? 4'h6 : (a == STRAP_OPEN) ? 4'h3 : 4'h0;
		ib = (b == STRAP_VCC) ? 4'h2 : (b == STRAP_OPEN) ? 4'h1 : 4'h0;
		addrOf = ADDR_TABLE[ia + ib];
	endfunction

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		next_convCnt = convCnt;
		next_rateTimer = rateTimer;
		next_oneShotRun = oneShotRun;
		next_cfgBits = cfgBits;
		next_rateCode = rateCode;
		next_flags = flags;
		next_thrPend = thrPend;
		next_stopArm = stopArm;
		next_alertLatch = alertLatch;
		next_strapCnt = strapCnt;
		next_strapDone = strapDone;
		next_slaveAddr = slaveAddr;
		startConv = 1'b0;
		convEnd = 1'b0;

		// Configuration and rate writes.
		if (cfgWrite)
		begin
			next_cfgBits = writeData[CFG_MASK_BIT:CFG_STANDBY_PIN_BIT];
		end
		if (rateWrite)
		begin
			next_rateCode = writeData[RATE_W-1:0];
		end
		newPeriod = periodOf(next_rateCode);
		standby = next_cfgBits[0] | ~stbyPinSync;

		// A timer that keeps counting through a conversion keeps the
		// interval measured from start to start, which holds tolerance.
		if (rateTimer != 32'h0)
		begin
			next_rateTimer = rateTimer - 32'h1;
		end
		if (rateWrite && next_rateTimer >= newPeriod)
		begin
			next_rateTimer = newPeriod - 32'h1;
		end

		case (state)
			TSCS_WAIT:
			begin
				if (standby)
				begin
					next_state = TSCS_STANDBY_PIN;
				end
				else if (oneShot || rateTimer == 32'h0)
				begin
					startConv = 1'b1;
					next_oneShotRun = 1'b0;
				end
			end
			TSCS_CONV:
			begin
				if (standby && !oneShotRun)
				begin
					next_state = TSCS_STANDBY_PIN;
				end
				else if (convCnt == 32'h0)
				begin
					convEnd = 1'b1;
					next_state = standby ? TSCS_STANDBY_PIN : TSCS_WAIT;
				end
				else
				begin
					next_convCnt = convCnt - 32'h1;
				end
			end
			TSCS_STANDBY_PIN:
			begin
				if (!standby)
				begin
					startConv = 1'b1;
					next_oneShotRun = 1'b0;
				end
				else if (oneShot)
				begin
					startConv = 1'b1;
					next_oneShotRun = 1'b1;
				end
			end
			default:
			begin
				next_state = TSCS_STANDBY_PIN;
			end
		endcase

		if (startConv)
		begin
			next_state = TSCS_CONV;
			next_convCnt = 32'(CONV_CYC) - 32'h1;
			next_rateTimer = newPeriod - 32'h1;
		end

		// Status flags: a read clears them, but a set in the same cycle
		// wins so that no event is lost.
		if (statusRead)
		begin
			next_flags = 5'h00;
		end
		if (startConv && openSync)
		begin
			next_flags[0] = 1'b1;
		end
		refresh = (stopArm && sclSync && !sclPrev) || busIdle;
		if (convEnd)
		begin
			next_thrPend = thrPend | {localOver, localUnder,
				remoteOver, remoteUnder};
		end
		if (refresh)
		begin
			next_flags[4:1] = next_flags[4:1] | next_thrPend;
			next_thrPend = 4'h0;
		end
		if (stopSeen)
		begin
			next_stopArm = 1'b1;
		end
		else if (sclSync && !sclPrev)
		begin
			next_stopArm = 1'b0;
		end

		// The alert latch lives apart from the status flags, so a read
		// collision can neither raise nor drop it.
		if (araRead)
		begin
			next_alertLatch = 1'b0;
		end
		if (((next_flags & ~flags) != 5'h00) && !next_cfgBits[1])
		begin
			next_alertLatch = 1'b1;
		end

		// Straps are caught once, after the synchroniser has filled.
		if (!strapDone)
		begin
			if (strapCnt == STRAP_SETTLE)
			begin
				next_strapDone = 1'b1;
				next_slaveAddr = addrOf(strapASync, strapBSync);
			end
			else
			begin
				next_strapCnt = strapCnt + 2'h1;
			end
		end

		busyNext = (next_state == TSCS_CONV);
		if (startConv || refresh || convEnd)
		begin
			next_statusByte = {busyNext, COLLISION_LOW};
		end
		else
		begin
			next_statusByte = {busyNext, next_flags, 2'b00};
		end
		next_convStart = startConv;
		next_resultLoad = convEnd;
		next_addrHit = addrValid && (addrIn == slaveAddr ||
			(addrIn == ARA_ADDR && alertLatch));
		next_alertOe = next_alertLatch && !next_cfgBits[1];
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge sysClk or posedge rst)
	begin
		if (rst)
		begin
			state <= TSCS_CONV;
			convCnt <= 32'(CONV_CYC) - 32'h1;
			rateTimer <= (32'(FAST_CYC) << (RATE_SLOWEST - RATE_RESET[2:0]))
				- 32'h1;
			oneShotRun <= 1'b0;
			cfgBits <= CFG_RESET[CFG_MASK_BIT:CFG_STANDBY_PIN_BIT];
			rateCode <= RATE_RESET[RATE_W-1:0];
			flags <= 5'h00;
			thrPend <= 4'h0;
			stopArm <= 1'b0;
			alertLatch <= 1'b0;
			strapCnt <= 2'h0;
			strapDone <= 1'b0;
			slaveAddr <= 7'h00;
			convStart <= 1'b1;
			resultLoad <= 1'b0;
			cfgByte <= CFG_RESET;
			rateByte <= RATE_RESET;
			statusByte <= 8'h80;
			araByte <= 8'h01;
			addrHit <= 1'b0;
			alertO <= 1'b0;
			alertOe <= 1'b0;
		end
		else
		begin
			state <= next_state;
			convCnt <= next_convCnt;
			rateTimer <= next_rateTimer;
			oneShotRun <= next_oneShotRun;
			cfgBits <= next_cfgBits;
			rateCode <= next_rateCode;
			flags <= next_flags;
			thrPend <= next_thrPend;
			stopArm <= next_stopArm;
			alertLatch <= next_alertLatch;
			strapCnt <= next_strapCnt;
			strapDone <= next_strapDone;
			slaveAddr <= next_slaveAddr;
			convStart <= next_convStart;
			resultLoad <= next_resultLoad;
			cfgByte <= {next_cfgBits, 6'h00};
			rateByte <= {5'h00, next_rateCode};
			statusByte <= next_statusByte;
			araByte <= {next_slaveAddr, 1'b1};
			addrHit <= next_addrHit;
			alertO <= 1'b0;
			alertOe <= next_alertOe;
		end
	end
endmodule

/* File: tscs_pkg.sv */
package tscs_pkg;
	localparam int CLK_MHZ = 125;
	localparam int CONV_TIME_US = 125000;
	localparam int CONV_CYCLES = CONV_TIME_US * CLK_MHZ;
	localparam int FAST_PERIOD_US = 125000;
	localparam int FAST_CYCLES = FAST_PERIOD_US * CLK_MHZ;
	localparam int CFG_MASK_BIT = 7;
	localparam int CFG_STANDBY_PIN_BIT = 6;
	localparam int ST_BUSY_BIT = 7;
	localparam int RATE_W = 3;
	localparam logic [2:0] RATE_SLOWEST = 3'h7;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] RATE_RESET = 8'h02;
	localparam logic [6:0] COLLISION_LOW = 7'h7f;
	localparam logic [6:0] ARA_ADDR = 7'h0c;
	localparam logic [1:0] STRAP_SETTLE = 2'h2;
	localparam logic [1:0] STRAP_GND = 2'h0;
	localparam logic [1:0] STRAP_OPEN = 2'h1;
	localparam logic [1:0] STRAP_VCC = 2'h2;
	localparam logic [6:0] ADDR_TABLE [9] = '{7'h18, 7'h19, 7'h1a,
		7'h29, 7'h2a, 7'h2b, 7'h4c, 7'h4d, 7'h4e};
	typedef enum logic [1:0]
	{
		TSCS_WAIT = 2'b00,
		TSCS_CONV = 2'b01,
		TSCS_STANDBY_PIN = 2'b11
	} tscs_state_t;
endpackage

/* File: tscs_checker.sv */
`timescale 1ns/100ps
module tscs_checker
#(
	parameter int CONV_CYC = tscs_pkg::CONV_CYCLES
)
(
	// Clock and reset
	input wire logic sysClk,
	input wire logic rst,
	// Strobes
	input wire logic oneShot,
	input wire logic araRead,
	input wire logic addrValid,
	input wire logic [6:0] addrIn,
	// Outputs
	input wire logic convStart,
	input wire logic resultLoad,
	input wire logic [7:0] cfgByte,
	input wire logic [7:0] statusByte,
	input wire logic [6:0] slaveAddr,
	input wire logic addrHit,
	input wire logic alertOe
);
	// ---------------
	// Helper counters
	// ---------------
	localparam int LO = CONV_CYC - 2;
	localparam int HI = CONV_CYC + 1;
	logic [31:0] age;
	logic [31:0] next_age;
	logic [2:0] since;
	logic [2:0] next_since;
	always_comb
	begin
		next_age = convStart ? 32'h1 : age + 32'h1;
		next_since = (since == 3'h5) ? since : since + 3'h1;
	end
	always_ff @(posedge sysClk or posedge rst)
	begin
		if (rst)
		begin
			age <= 32'h0;
			since <= 3'h0;
		end
		else
		begin
			age <= next_age;
			since <= next_since;
		end
	end
	// ----------
	// Properties
	// ----------
	default clocking @(posedge sysClk); endclocking
	default disable iff (rst);
	sequence s_hit; ##1 addrHit; endsequence
	sequence s_araLow; ##[1:2] !alertOe; endsequence
	property p_mask; cfgByte[7] && $past(cfgByte[7]) |-> !alertOe; endproperty
	property p_standby_pin; cfgByte[6] && !$past(oneShot) |-> !convStart; endproperty
	property p_busy; convStart |-> statusByte[7]; endproperty
	property p_rsv; statusByte[6:0] != 7'h7f |-> statusByte[1:0] == 2'h0;
	endproperty
	property p_len; resultLoad |-> age inside {[LO:HI]}; endproperty
	property p_ara; araRead |-> s_araLow; endproperty
	property p_hold; since == 3'h5 |-> $stable(slaveAddr); endproperty
	property p_hit; since == 3'h5 && addrValid && addrIn == slaveAddr
		|-> s_hit; endproperty
	a_mask: assert property (p_mask) else $error("alert while masked");
	a_standby_pin: assert property (p_standby_pin) else $error("start in standby");
	a_busy: assert property (p_busy) else $error("busy low at start");
	a_rsv: assert property (p_rsv) else $error("reserved bits set");
	a_len: assert property (p_len) else $error("conversion length");
	a_ara: assert property (p_ara) else $error("alert not cleared");
	a_hold: assert property (p_hold) else $error("address moved");
	a_hit: assert property (p_hit) else $error("own address missed");
endmodule
bind tscs_conv_status tscs_checker #(.CONV_CYC(CONV_CYC)) chk (.sysClk, .rst,
	.oneShot, .araRead, .addrValid, .addrIn, .convStart, .resultLoad,
	.cfgByte, .statusByte, .slaveAddr, .addrHit, .alertOe);

/* File: tscs_host_model.sv */
`timescale 1ns/100ps
module tscs_host_model
(
	// Frame request and bus clock
	input wire logic frameOn,
	output logic smbClk
);
	// ---------
	// Bus clock
	// ---------
	logic phase = 1'b1;
	// Own phase; the pull-up holds the line high between frames.
	initial
	begin
		#3;
		forever #32 phase = ~phase;
	end
	assign smbClk = frameOn ? phase : 1'b1;
endmodule

/* File: test_tscs_conv_status.sv */
`timescale 1ns/100ps
module test_tscs_conv_status;
	import tscs_pkg::*;
	// -----
	// Bench
	// -----
	logic sysClk = 1'b0;
	logic rst = 1'b1;
	logic [5:0] stb = 6'h0;
	logic [7:0] writeData = 8'h0;
	logic addrValid = 1'b0;
	logic [6:0] addrIn = 7'h0;
	logic frameOn = 1'b0;
	logic standbyPinN = 1'b1;
	logic diodeOpen = 1'b0;
	logic [1:0] strapA = 2'h1;
	logic [1:0] strapB = 2'h2;
	logic [3:0] cmp = 4'h0;
	logic smbClk, convStart, resultLoad, addrHit, alertOe, alertO;
	logic [7:0] cfgByte, rateByte, statusByte, araByte, v;
	logic [6:0] slaveAddr;
	int errorCnt = 0;
	int cmpCount = 0;
	int convN = 0;
	int n, g, c;
	always #4 sysClk = ~sysClk;
	always @(posedge sysClk) convN <= convN + int'(convStart);
	tscs_conv_status #(.CONV_CYC(20), .FAST_CYC(40)) DUT (.sysClk, .rst,
		.cfgWrite(stb[0]), .rateWrite(stb[1]), .writeData,
		.statusRead(stb[2]), .oneShot(stb[3]), .araRead(stb[4]),
		.stopSeen(stb[5]), .busIdle(1'b0), .addrValid, .addrIn, .smbClk,
		.standbyPinN, .diodeOpen, .strapA, .strapB, .localOver(cmp[3]),
		.localUnder(cmp[2]), .remoteOver(cmp[1]), .remoteUnder(cmp[0]),
		.convStart, .resultLoad, .cfgByte, .rateByte, .statusByte,
		.araByte, .slaveAddr, .addrHit, .alertO, .alertOe);
	tscs_host_model HOST (.frameOn, .smbClk);
	task check(input string name, input logic [7:0] seen, exp);
		cmpCount++;
		if (seen !== exp)
		begin
			errorCnt++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task completeRun;
		$display("Comparisons %0d mismatches %0d", cmpCount, errorCnt);
		if (errorCnt == 0 && cmpCount > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task pulse(input logic [5:0] m, input logic [7:0] d);
		@(negedge sysClk);
		stb = m;
		writeData = d;
		@(negedge sysClk);
		stb = 6'h0;
	endtask
	task waitOn(input bit load, output int cnt);
		cnt = 0;
		do
		begin
			@(negedge sysClk);
			cnt++;
		end
		while ((load ? resultLoad : convStart) !== 1'b1 && cnt < 7000);
	endtask
	task rdStatus(output logic [7:0] r);
		@(negedge sysClk);
		for (int i = 0; i < 8 && statusByte[6:0] === 7'h7f; i++)
			@(negedge sysClk);
		r = statusByte;
		pulse(6'h04, 8'h0);
	endtask
	initial
	begin
		repeat (50000) @(posedge sysClk);
		errorCnt++;
		completeRun;
	end
	initial
	begin
		repeat (12) @(negedge sysClk);
		rst = 1'b0;
		repeat (6) @(negedge sysClk);
		check("rate", rateByte, RATE_RESET);
		check("ara", araByte, 8'h57);
		strapA = 2'h0;
		repeat (4) @(negedge sysClk);
		check("addr", {1'b0, slaveAddr}, 8'h2b);
		addrValid = 1'b1;
		addrIn = 7'h2b;
		@(negedge sysClk);
		addrValid = 1'b0;
		check("hit", {7'h0, addrHit}, 8'h1);
		$display("Test address done");
		for (int k = 0; k < 8; k++)
		begin
			pulse(6'h02, {5'h1f, 3'(7 - k)});
			check("rate", rateByte, {5'h0, 3'(7 - k)});
			waitOn(0, g);
			waitOn(0, g);
			check("gap", {7'h0, g >= 30 << k && g <= 50 << k}, 8'h1);
		end
		pulse(6'h02, 8'h07);
		standbyPinN = 1'b0;
		n = convN;
		repeat (200) @(negedge sysClk);
		check("pinStby", 8'(convN - n), 8'h0);
		standbyPinN = 1'b1;
		$display("Test rate done");
		waitOn(0, g);
		pulse(6'h01, 8'h40);
		check("cfg", cfgByte, 8'h40);
		n = convN;
		repeat (200) @(negedge sysClk);
		check("swStby", 8'(convN - n), 8'h0);
		diodeOpen = 1'b1;
		// The pin passes two flip-flops before the start can see it.
		repeat (2) @(negedge sysClk);
		pulse(6'h08, 8'h0);
		pulse(6'h08, 8'h0);
		waitOn(1, c);
		repeat (50) @(negedge sysClk);
		check("shots", 8'(convN - n), 8'h1);
		rdStatus(v);
		check("open", v, 8'h04);
		check("alert", {7'h0, alertOe}, 8'h1);
		diodeOpen = 1'b0;
		rdStatus(v);
		check("cleared", v, 8'h00);
		check("latch", {7'h0, alertOe}, 8'h1);
		pulse(6'h01, 8'hc0);
		@(negedge sysClk);
		check("mask", {7'h0, alertOe}, 8'h0);
		check("alertOut", {7'h0, alertO}, 8'h0);
		pulse(6'h01, 8'h40);
		@(negedge sysClk);
		check("unmask", {7'h0, alertOe}, 8'h1);
		addrValid = 1'b1;
		addrIn = ARA_ADDR;
		@(negedge sysClk);
		addrValid = 1'b0;
		check("araHit", {7'h0, addrHit}, 8'h1);
		pulse(6'h10, 8'h0);
		@(negedge sysClk);
		check("araClr", {7'h0, alertOe}, 8'h0);
		$display("Test standby done");
		cmp = 4'h9;
		pulse(6'h08, 8'h0);
		waitOn(1, c);
		check("convTime", {7'h0, c <= 22}, 8'h1);
		cmp = 4'h0;
		repeat (10) @(negedge sysClk);
		check("pend", {4'h0, statusByte[6:3]}, 8'h0);
		pulse(6'h20, 8'h0);
		frameOn = 1'b1;
		repeat (20) @(negedge sysClk);
		frameOn = 1'b0;
		rdStatus(v);
		check("thresh", v, 8'h48);
		$display("Test flags done");
		pulse(6'h02, 8'h06);
		pulse(6'h01, 8'h00);
		waitOn(1, c);
		repeat (10) @(negedge sysClk);
		pulse(6'h08, 8'h0);
		check("osStart", {7'h0, convStart}, 8'h1);
		waitOn(1, c);
		check("osTime", {7'h0, c <= 22}, 8'h1);
		waitOn(0, g);
		check("restart", {7'h0, c + g >= 60 && c + g <= 100}, 8'h1);
		// A faster rate written mid-interval must cut the wait short.
		pulse(6'h02, 8'h07);
		waitOn(0, g);
		check("rateChg", {7'h0, g <= 50}, 8'h1);
		$display("Test auto done");
		completeRun;
	end
endmodule
